// [verilog/cvsc_control_status.sv]
`timescale 1ns/1ps
// control and status registers of the delta/pcm converter
module cvsc_control_status
    import cvsc_pkg::*;
#(
    parameter int FIFO_DEPTH = CVSC_FIFO_WORDS,
    parameter int CNT_W = $clog2(FIFO_DEPTH + 1)
)
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic bus_sel,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    output logic [15:0] bus_rdata,
    input wire logic freeze,
    input wire logic [CNT_W-1:0] infifo_count,
    input wire logic [CNT_W-1:0] outfifo_count,
    input wire logic core_infifo_rd,
    input wire logic core_outfifo_wr,
    input wire logic sample_output_full,
    input wire logic sample_input_empty,
    input wire logic [15:0] sample_data,
    input wire logic sample_data_is_log,
    output logic module_enable_bit,
    output logic converter_clock_gate,
    output logic converter_hold,
    output logic [1:0] delta_format_select,
    output logic compander_select,
    output logic [1:0] atten_shift,
    output logic [15:0] atten_data,
    output logic irq,
    output logic outfifo_dma_req,
    output logic infifo_dma_req,
    output logic sample_out_dma_req,
    output logic sample_in_dma_req
);
    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // level fields are three bits wide and clamp; thresholds need depth >= 8
    if (FIFO_DEPTH < 8 || FIFO_DEPTH > 15) begin : g_bad_depth
        $error("cvsc_control_status: FIFO_DEPTH must lie in 8..15");
    end
    if (CNT_W < $clog2(FIFO_DEPTH + 1)) begin : g_bad_cnt
        $error("cvsc_control_status: CNT_W too narrow for FIFO_DEPTH");
    end

    localparam logic [CNT_W-1:0] NE_CNT = CNT_W'(CVSC_NEAR_LEFT);
    localparam logic [CNT_W-1:0] NF_CNT = CNT_W'(FIFO_DEPTH - CVSC_NEAR_LEFT);
    localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(FIFO_DEPTH);
    localparam logic [CNT_W-1:0] TOP_CNT = CNT_W'(FIFO_DEPTH - 1);
    localparam logic [CNT_W-1:0] LVL_CNT = CNT_W'(CVSC_LVL_MAX);

    logic [15:0] converter_control;
    logic ne_flag;
    logic nf_flag;
    logic svc_flag;
    logic und_flag;
    logic ovf_flag;
    logic [2:0] in_lvl;
    logic [2:0] out_lvl;
    logic [CNT_W-1:0] in_cnt_q;
    logic [CNT_W-1:0] out_cnt_q;
    logic so_full_q;
    logic si_empty_q;
    logic [15:0] converter_status;
    logic ctrl_wr;
    logic stat_rd;
    logic en;
    logic ne_set;
    logic nf_set;
    logic svc_set;
    logic und_set;
    logic ovf_set;
    logic sticky_clr;
    logic [2:0] next_in_lvl;
    logic [2:0] next_out_lvl;
    logic [15:0] next_atten;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    assign ctrl_wr = bus_sel && bus_wr && (bus_addr == CVSC_CTRL_OFS);
    assign stat_rd = bus_sel && bus_rd && (bus_addr == CVSC_STAT_OFS);
    assign en = converter_control[CVSC_C_EN];
    // freeze keeps the error and service flags through a status read
    assign sticky_clr = stat_rd && !freeze;

    // control register, writable at any time, unimplemented bits kept zero
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            converter_control <= CVSC_CTRL_RESET;
        end else if (ctrl_wr) begin
            converter_control <= bus_wdata & CVSC_CTRL_MASK;
        end
    end

    // ------------------------------------------------------------
    // event detection
    // ------------------------------------------------------------
    // previous counts and buffer levels so that only arrival edges set flags
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            in_cnt_q <= '0;
            out_cnt_q <= '0;
            so_full_q <= 1'b0;
            si_empty_q <= 1'b0;
        end else begin
            in_cnt_q <= infifo_count;
            out_cnt_q <= outfifo_count;
            so_full_q <= sample_output_full;
            si_empty_q <= sample_input_empty;
        end
    end

    // a frozen core moves no data, so its strobes are ignored then
    assign ne_set = (infifo_count == NE_CNT) && (in_cnt_q != NE_CNT);
    assign nf_set = (outfifo_count == NF_CNT) && (out_cnt_q != NF_CNT);
    assign svc_set = (sample_output_full && !so_full_q) || (sample_input_empty && !si_empty_q);
    assign und_set = core_infifo_rd && !freeze && (infifo_count == '0);
    assign ovf_set = core_outfifo_wr && !freeze && (outfifo_count == FULL_CNT);

    // ------------------------------------------------------------
    // sticky status flags
    // ------------------------------------------------------------
    // set wins over the read clear so an event in the read cycle survives
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ne_flag <= 1'b0;
            nf_flag <= 1'b0;
            svc_flag <= 1'b0;
            und_flag <= 1'b0;
            ovf_flag <= 1'b0;
        end else if (!en) begin
            ne_flag <= 1'b0;
            nf_flag <= 1'b0;
            svc_flag <= 1'b0;
            und_flag <= 1'b0;
            ovf_flag <= 1'b0;
        end else begin
            ne_flag <= ne_set || (ne_flag && !stat_rd);
            nf_flag <= nf_set || (nf_flag && !stat_rd);
            svc_flag <= svc_set || (svc_flag && !sticky_clr);
            und_flag <= und_set || (und_flag && !sticky_clr);
            ovf_flag <= ovf_set || (ovf_flag && !sticky_clr);
        end
    end

    // ------------------------------------------------------------
    // fifo level fields
    // ------------------------------------------------------------
    // three-bit fields cannot show eight, so seven and eight read alike
    always_comb begin
        if (infifo_count >= TOP_CNT) begin
            next_in_lvl = 3'h0;
        end else if ((TOP_CNT - infifo_count) > LVL_CNT) begin
            next_in_lvl = CVSC_LVL_MAX;
        end else begin
            next_in_lvl = 3'(TOP_CNT - infifo_count);
        end
        if (outfifo_count >= LVL_CNT) begin
            next_out_lvl = CVSC_LVL_MAX;
        end else begin
            next_out_lvl = 3'(outfifo_count);
        end
    end

    // levels follow the counts one cycle late and read zero when disabled
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            in_lvl <= 3'h0;
            out_lvl <= 3'h0;
        end else if (!en) begin
            in_lvl <= 3'h0;
            out_lvl <= 3'h0;
        end else begin
            in_lvl <= next_in_lvl;
            out_lvl <= next_out_lvl;
        end
    end

    // status word, bits above the out level read zero
    assign converter_status = {5'h00, out_lvl, in_lvl, ovf_flag, und_flag, svc_flag, nf_flag, ne_flag};

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    // data appears the cycle after the strobe; unmapped offsets read zero
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_rdata <= 16'h0000;
        end else if (bus_sel && bus_rd) begin
            if (bus_addr == CVSC_CTRL_OFS) begin
                bus_rdata <= converter_control;
            end else if (bus_addr == CVSC_STAT_OFS) begin
                bus_rdata <= converter_status;
            end else begin
                bus_rdata <= 16'h0000;
            end
        end
    end

    // ------------------------------------------------------------
    // control outputs to the converter core
    // ------------------------------------------------------------
    // the core clock gate itself sits beside the core; this is its enable
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            module_enable_bit <= 1'b0;
            converter_clock_gate <= 1'b0;
            converter_hold <= 1'b0;
            delta_format_select <= CVSC_FMT_MULAW;
            compander_select <= CVSC_CMP_MULAW;
            atten_shift <= 2'h0;
        end else begin
            module_enable_bit <= en;
            converter_clock_gate <= converter_control[CVSC_C_CLK];
            converter_hold <= freeze;
            delta_format_select <= converter_control[CVSC_C_FMT +: 2];
            compander_select <= converter_control[CVSC_C_CMP];
            atten_shift <= converter_control[CVSC_C_ATT +: 2];
        end
    end

    // ------------------------------------------------------------
    // sample attenuation path
    // ------------------------------------------------------------
    cvsc_atten_shift u_atten (
        .sample_in(sample_data),
        .from_log(sample_data_is_log),
        .log_is_alaw(converter_control[CVSC_C_FMT +: 2] == CVSC_FMT_ALAW),
        .atten(converter_control[CVSC_C_ATT +: 2]),
        .sample_out(next_atten)
    );

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            atten_data <= 16'h0000;
        end else begin
            atten_data <= next_atten;
        end
    end

    // ------------------------------------------------------------
    // interrupt and dma requests
    // ------------------------------------------------------------
    // irq and fifo dma requests follow the flags, so a status read drops them but not a frozen error or service irq; sample buffer requests follow the levels
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
            outfifo_dma_req <= 1'b0;
            infifo_dma_req <= 1'b0;
            sample_out_dma_req <= 1'b0;
            sample_in_dma_req <= 1'b0;
        end else begin
            irq <= (converter_control[CVSC_C_PCMIE] && svc_flag)
                || (converter_control[CVSC_C_WMIE] && (ne_flag || nf_flag))
                || (converter_control[CVSC_C_ERRIE] && (und_flag || ovf_flag));
            outfifo_dma_req <= converter_control[CVSC_C_OUTDMA] && nf_flag;
            infifo_dma_req <= converter_control[CVSC_C_INDMA] && ne_flag;
            sample_out_dma_req <= en && converter_control[CVSC_C_SODMA] && sample_output_full;
            sample_in_dma_req <= en && converter_control[CVSC_C_SIDMA] && sample_input_empty;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence s_nf_arrive;
        en && (outfifo_count == NF_CNT) && (out_cnt_q != NF_CNT);
    endsequence
    sequence s_ne_arrive;
        en && (infifo_count == NE_CNT) && (in_cnt_q != NE_CNT);
    endsequence

    property p_ctrl_write;
        ctrl_wr |=> (converter_control == ($past(bus_wdata) & CVSC_CTRL_MASK));
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write not stored");

    property p_stat_disabled;
        !en |=> (converter_status == CVSC_STAT_RESET);
    endproperty
    a_stat_disabled: assert property (p_stat_disabled) else $error("status not clear while disabled");

    property p_pcm_irq;
        (converter_control[CVSC_C_PCMIE] && svc_flag) |=> irq;
    endproperty
    a_pcm_irq: assert property (p_pcm_irq) else $error("service interrupt missing");

    property p_no_irq;
        (converter_control[4:2] == 3'h0) |=> !irq;
    endproperty
    a_no_irq: assert property (p_no_irq) else $error("interrupt raised while disabled");

    property p_wm_irq;
        s_ne_arrive ##1 converter_control[CVSC_C_WMIE] |=> irq;
    endproperty
    a_wm_irq: assert property (p_wm_irq) else $error("watermark interrupt missing");

    property p_err_irq;
        (en && und_set) ##1 converter_control[CVSC_C_ERRIE] |=> irq;
    endproperty
    a_err_irq: assert property (p_err_irq) else $error("error interrupt missing");

    property p_out_dma;
        s_nf_arrive ##1 converter_control[CVSC_C_OUTDMA] |=> outfifo_dma_req;
    endproperty
    a_out_dma: assert property (p_out_dma) else $error("outfifo dma request missing");

    property p_in_dma;
        s_ne_arrive ##1 converter_control[CVSC_C_INDMA] |=> infifo_dma_req;
    endproperty
    a_in_dma: assert property (p_in_dma) else $error("infifo dma request missing");

    property p_ne_clear;
        (en && stat_rd && !ne_set) |=> !ne_flag;
    endproperty
    a_ne_clear: assert property (p_ne_clear) else $error("nearly empty not cleared by read");

    property p_freeze_keep;
        (en && freeze && stat_rd && und_flag) ##1 en |-> und_flag;
    endproperty
    a_freeze_keep: assert property (p_freeze_keep) else $error("underrun lost under freeze");

    property p_in_level;
        (en && infifo_count == '0) ##1 en |-> (in_lvl == CVSC_LVL_MAX);
    endproperty
    a_in_level: assert property (p_in_level) else $error("empty infifo level wrong");

    property p_out_level;
        (en && outfifo_count >= TOP_CNT) ##1 en |-> (out_lvl == CVSC_LVL_MAX);
    endproperty
    a_out_level: assert property (p_out_level) else $error("full outfifo level wrong");
endmodule : cvsc_control_status

// [verilog/cvsc_pkg.sv]
package cvsc_pkg;
    // ------------------------------------------------------------
    // register offsets on the peripheral bus (low address byte)
    // ------------------------------------------------------------
    localparam logic [7:0] CVSC_CTRL_OFS = 8'h30;
    localparam logic [7:0] CVSC_STAT_OFS = 8'h32;
    localparam logic [15:0] CVSC_CTRL_RESET = 16'h0000;
    localparam logic [15:0] CVSC_CTRL_MASK = 16'h3FFF;
    localparam logic [15:0] CVSC_STAT_RESET = 16'h0000;
    // ------------------------------------------------------------
    // control field positions
    // ------------------------------------------------------------
    localparam int CVSC_C_EN = 0;
    localparam int CVSC_C_CLK = 1;
    localparam int CVSC_C_PCMIE = 2;
    localparam int CVSC_C_WMIE = 3;
    localparam int CVSC_C_ERRIE = 4;
    localparam int CVSC_C_OUTDMA = 5;
    localparam int CVSC_C_INDMA = 6;
    localparam int CVSC_C_SODMA = 7;
    localparam int CVSC_C_SIDMA = 8;
    localparam int CVSC_C_FMT = 9;
    localparam int CVSC_C_CMP = 11;
    localparam int CVSC_C_ATT = 12;
    // ------------------------------------------------------------
    // status field positions
    // ------------------------------------------------------------
    localparam int CVSC_S_NE = 0;
    localparam int CVSC_S_NF = 1;
    localparam int CVSC_S_SVC = 2;
    localparam int CVSC_S_UND = 3;
    localparam int CVSC_S_OVF = 4;
    localparam int CVSC_S_INLVL = 5;
    localparam int CVSC_S_OUTLVL = 8;
    // ------------------------------------------------------------
    // formats, thresholds, sizes
    // ------------------------------------------------------------
    localparam logic [1:0] CVSC_FMT_MULAW = 2'h0;
    localparam logic [1:0] CVSC_FMT_ALAW = 2'h1;
    localparam logic [1:0] CVSC_FMT_LINEAR = 2'h2;
    localparam logic CVSC_CMP_MULAW = 1'h0;
    localparam logic CVSC_CMP_ALAW = 1'h1;
    localparam int CVSC_NEAR_LEFT = 3;
    localparam int CVSC_FIFO_WORDS = 8;
    localparam logic [2:0] CVSC_LVL_MAX = 3'h7;
    localparam logic [15:0] CVSC_ALAW_KEEP = 16'hFFF8;
    localparam logic [15:0] CVSC_MULAW_KEEP = 16'hFFFC;
endpackage : cvsc_pkg

// [verilog/cvsc_atten_shift.sv]
`timescale 1ns/1ps
// expansion masking and attenuation of the pcm sample before delta coding
module cvsc_atten_shift
    import cvsc_pkg::*;
(
    input wire logic [15:0] sample_in,
    input wire logic from_log,
    input wire logic log_is_alaw,
    input wire logic [1:0] atten,
    output logic [15:0] sample_out
);
    logic [15:0] expanded;

    // ------------------------------------------------------------
    // expansion then shift
    // ------------------------------------------------------------
    // log data keeps 13 (A) or 14 (mu) msbs, the rest zero-filled
    always_comb begin
        if (from_log && log_is_alaw) begin
            expanded = sample_in & CVSC_ALAW_KEEP;
        end else if (from_log) begin
            expanded = sample_in & CVSC_MULAW_KEEP;
        end else begin
            expanded = sample_in;
        end
        // shift happens after expansion, so it covers both sources
        sample_out = 16'($signed(expanded) >>> atten);
    end
endmodule : cvsc_atten_shift

// [verif/cvsc_core_model.sv]
`timescale 1ns/1ps
// converter core and fifo side; the bench steers it by task calls
module cvsc_core_model (
    input wire logic core_clk,
    input wire logic freeze,
    output logic [3:0] infifo_count,
    output logic [3:0] outfifo_count,
    output logic core_infifo_rd,
    output logic core_outfifo_wr,
    output logic sample_output_full,
    output logic sample_input_empty
);
    // -----------------------------------------
    // idle state; counts stay in 0..8
    // -----------------------------------------
    initial begin
        infifo_count = 4'h0;
        outfifo_count = 4'h0;
        core_infifo_rd = 1'b0;
        core_outfifo_wr = 1'b0;
        sample_output_full = 1'b0;
        sample_input_empty = 1'b0;
    end
    // fill levels move off the sampling edge
    task automatic set_counts(input logic [3:0] in_c, input logic [3:0] out_c);
        @(negedge core_clk);
        infifo_count = in_c;
        outfifo_count = out_c;
    endtask : set_counts
    // one-cycle fifo moves, withheld while frozen
    task automatic core_move(input logic rd, input logic wr);
        @(negedge core_clk);
        core_infifo_rd = rd & ~freeze;
        core_outfifo_wr = wr & ~freeze;
        @(negedge core_clk);
        core_infifo_rd = 1'b0;
        core_outfifo_wr = 1'b0;
    endtask : core_move
    // sample buffer state levels
    task automatic set_buf(input logic full, input logic empty);
        @(negedge core_clk);
        sample_output_full = full;
        sample_input_empty = empty;
    endtask : set_buf
endmodule : cvsc_core_model

// [verif/tb_cvsc_control_status.sv]
`timescale 1ns/1ps
module tb_cvsc_control_status
    import cvsc_pkg::*;
;
    logic core_clk, rst_b, bus_sel, bus_wr, bus_rd, freeze, sample_data_is_log;
    logic [7:0] bus_addr;
    logic [15:0] bus_wdata, bus_rdata, sample_data, atten_data;
    logic [3:0] infifo_count, outfifo_count;
    logic core_infifo_rd, core_outfifo_wr, sample_output_full, sample_input_empty;
    logic module_enable_bit, converter_clock_gate, converter_hold, compander_select, irq;
    logic [1:0] delta_format_select, atten_shift;
    logic outfifo_dma_req, infifo_dma_req, sample_out_dma_req, sample_in_dma_req;
    int error_cnt = 0;
    int compares = 0;
    logic [15:0] atab [4][4];

    cvsc_control_status dut (.core_clk(core_clk), .rst_b(rst_b), .bus_sel(bus_sel), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .freeze(freeze),
        .infifo_count(infifo_count), .outfifo_count(outfifo_count), .core_infifo_rd(core_infifo_rd),
        .core_outfifo_wr(core_outfifo_wr), .sample_output_full(sample_output_full),
        .sample_input_empty(sample_input_empty), .sample_data(sample_data),
        .sample_data_is_log(sample_data_is_log), .module_enable_bit(module_enable_bit),
        .converter_clock_gate(converter_clock_gate), .converter_hold(converter_hold),
        .delta_format_select(delta_format_select), .compander_select(compander_select),
        .atten_shift(atten_shift), .atten_data(atten_data), .irq(irq), .outfifo_dma_req(outfifo_dma_req),
        .infifo_dma_req(infifo_dma_req), .sample_out_dma_req(sample_out_dma_req),
        .sample_in_dma_req(sample_in_dma_req));

    cvsc_core_model core (.core_clk(core_clk), .freeze(freeze), .infifo_count(infifo_count),
        .outfifo_count(outfifo_count), .core_infifo_rd(core_infifo_rd), .core_outfifo_wr(core_outfifo_wr),
        .sample_output_full(sample_output_full), .sample_input_empty(sample_input_empty));

    // ------------------------------------------------------------
    // clock
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------
    // bus tasks and compares; strobes are single-cycle pulses
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask : tick
    task automatic bus_write(input logic [7:0] a, input logic [15:0] d);
        @(negedge core_clk);
        bus_sel = 1'b1;
        bus_wr = 1'b1;
        bus_addr = a;
        bus_wdata = d;
        @(negedge core_clk);
        bus_sel = 1'b0;
        bus_wr = 1'b0;
    endtask : bus_write
    // read data is registered, so it is seen one cycle after the strobe
    task automatic bus_read(input logic [7:0] a, output logic [15:0] d);
        @(negedge core_clk);
        bus_sel = 1'b1;
        bus_rd = 1'b1;
        bus_addr = a;
        @(negedge core_clk);
        bus_sel = 1'b0;
        bus_rd = 1'b0;
        d = bus_rdata;
    endtask : bus_read
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic chk_reg(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        bus_read(a, d);
        chk($sformatf("reg %h", a), exp, d);
    endtask : chk_reg
    task automatic close_out();
        if (error_cnt == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        // control word, sample, is-log, expected attenuated sample
        atab = '{'{16'h3001, 16'h8000, 16'h0, 16'hF000}, '{16'h0001, 16'h7FFF, 16'h1, 16'h7FFC},
                 '{16'h1A01, 16'h7FFF, 16'h1, 16'h3FFC}, '{16'h2001, 16'h4004, 16'h0, 16'h1001}};
        rst_b = 1'b0;
        {bus_sel, bus_wr, bus_rd, freeze, sample_data_is_log} = 5'h00;
        bus_addr = 8'h00;
        bus_wdata = 16'h0000;
        sample_data = 16'h0000;
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        rst_b = 1'b1;
        chk_reg(CVSC_CTRL_OFS, 16'h0000);
        chk_reg(CVSC_STAT_OFS, 16'h0000);
        chk_reg(8'h34, 16'h0000);
        bus_write(CVSC_CTRL_OFS, 16'hFFFF);
        chk_reg(CVSC_CTRL_OFS, 16'h3FFF);
        chk_reg(CVSC_STAT_OFS, 16'h00E0);
        chk("gates", 16'h0003, {14'h0, converter_clock_gate, module_enable_bit});
        for (int i = 0; i < 4; i++) begin
            bus_write(CVSC_CTRL_OFS, 16'h0001 | (16'(i) << 9) | (16'(i & 1) << 11));
            tick(2);
            chk("format", 16'(i), {14'h0, delta_format_select});
            chk("compander", 16'(i & 1), {15'h0, compander_select});
        end
        // attenuation table: shift and log masking
        for (int i = 0; i < 4; i++) begin
            bus_write(CVSC_CTRL_OFS, atab[i][0]);
            sample_data = atab[i][1];
            sample_data_is_log = atab[i][2][0];
            tick(2);
            chk("atten_data", atab[i][3], atten_data);
            chk("atten_shift", {14'h0, atab[i][0][13:12]}, {14'h0, atten_shift});
        end
        sample_data_is_log = 1'b0;
        // watermark on the output fifo, then the input fifo
        bus_write(CVSC_CTRL_OFS, 16'h0029);
        core.set_counts(4'h0, 4'h4);
        chk_reg(CVSC_STAT_OFS, 16'h04E0);
        core.set_counts(4'h0, 4'h5);
        tick(3);
        chk("wm irq", 16'h1, {15'h0, irq});
        chk("out dma", 16'h1, {15'h0, outfifo_dma_req});
        chk_reg(CVSC_STAT_OFS, 16'h05E2);
        chk_reg(CVSC_STAT_OFS, 16'h05E0);
        bus_write(CVSC_CTRL_OFS, 16'h0049);
        core.set_counts(4'h3, 4'h5);
        tick(3);
        chk("in dma", 16'h1, {15'h0, infifo_dma_req});
        chk_reg(CVSC_STAT_OFS, 16'h0581);
        bus_write(CVSC_CTRL_OFS, 16'h0001);
        core.set_counts(4'h4, 4'h5);
        core.set_counts(4'h3, 4'h5);
        tick(3);
        chk("wm masked", 16'h0, {14'h0, irq, infifo_dma_req});
        chk_reg(CVSC_STAT_OFS, 16'h0581);
        // underrun and overflow, kept across reads while frozen
        bus_write(CVSC_CTRL_OFS, 16'h0011);
        core.set_counts(4'h0, 4'h8);
        core.core_move(1'b1, 1'b1);
        tick(2);
        chk("err irq", 16'h1, {15'h0, irq});
        freeze = 1'b1;
        chk_reg(CVSC_STAT_OFS, 16'h07F8);
        chk("hold", 16'h1, {15'h0, converter_hold});
        chk_reg(CVSC_STAT_OFS, 16'h07F8);
        freeze = 1'b0;
        chk_reg(CVSC_STAT_OFS, 16'h07F8);
        chk_reg(CVSC_STAT_OFS, 16'h07E0);
        core.set_counts(4'h8, 4'h0);
        chk_reg(CVSC_STAT_OFS, 16'h0000);
        // sample buffer service, with and without its interrupt
        bus_write(CVSC_CTRL_OFS, 16'h0085);
        core.set_buf(1'b1, 1'b0);
        tick(3);
        chk("svc irq", 16'h3, {14'h0, irq, sample_out_dma_req});
        chk_reg(CVSC_STAT_OFS, 16'h0004);
        chk_reg(CVSC_STAT_OFS, 16'h0000);
        bus_write(CVSC_CTRL_OFS, 16'h0001);
        core.set_buf(1'b1, 1'b1);
        tick(3);
        chk("svc masked", 16'h0, {13'h0, irq, sample_out_dma_req, sample_in_dma_req});
        // input buffer still empty, so its dma enable alone raises the request
        bus_write(CVSC_CTRL_OFS, 16'h0101);
        tick(2);
        chk("in buf dma", 16'h1, {15'h0, sample_in_dma_req});
        // disabling the module wipes pending status
        bus_write(CVSC_CTRL_OFS, 16'h0000);
        tick(2);
        chk("enable", 16'h0, {15'h0, module_enable_bit});
        chk_reg(CVSC_STAT_OFS, 16'h0000);
        close_out();
    end
endmodule : tb_cvsc_control_status
